// ===== rtl/clock_divider_sleep_control.sv
// Oscillator trim, glitch-free system clock divider and sleep mode clock gating
`timescale 1ns/100ps
module clock_divider_sleep_control #(
    parameter int STARTUP_CYCLES = clock_sleep_pkg::STARTUP_CYCLES_DEFAULT
) (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Straps and chip context
    input  wire logic [7:0]  factoryTrim,
    input  wire logic        div8FuseProgrammed,
    input  wire logic        extCrystalSelected,
    input  wire logic        lcdAsync,
    input  wire logic        timer2Async,
    input  wire logic        converterEnabled,
    input  wire logic        sleepInstr,
    // Wake requests, already qualified by their own enables
    input  wire logic        extIntZero,
    input  wire logic        extIntZeroLevel,
    input  wire logic        pinChangeWake,
    input  wire logic        serialStartWake,
    input  wire logic        lcdWake,
    input  wire logic        timer2Wake,
    input  wire logic        memReadyWake,
    input  wire logic        converterWake,
    input  wire logic        otherIoWake,
    // Oscillator trim
    output logic [7:0]       oscillatorTrim,
    output logic             rangeSelectBit,
    output logic [6:0]       fineTrimBits,
    // Clock gating
    output logic             sysClkTick,
    output logic             cpuClockEn,
    output logic             flashClockEn,
    output logic             ioClockEn,
    output logic             converterClockEn,
    output logic             asyncClockEn,
    output logic             mainOscEn,
    output logic             timerOscEn,
    output logic             converterStart,
    output logic             sleeping,
    output logic             resumeRun
);
    typedef clock_sleep_pkg::sleep_mode_t  mode_t;
    typedef clock_sleep_pkg::sleep_state_t state_t;

    // Terminal count of the divider for a code; reserved codes stay at 255, division by 256
    function automatic logic [7:0] divTerminal(input logic [3:0] code);
        logic [3:0] c;
        c = (code > clock_sleep_pkg::DIV_MAX_CODE) ? clock_sleep_pkg::DIV_MAX_CODE : code;
        divTerminal = 8'(9'((9'h001 << c) - 9'h001));
    endfunction : divTerminal

    // APB decode
    logic       setup;
    logic       access;
    logic       wrByte0;
    logic [9:0] wordAddr;
    logic       hitDivider;
    logic       hitTrim;
    logic       hitSleep;
    logic       hitStatus;
    logic       mapped;
    logic [7:0] wrData;

    assign setup      = psel & ~penable;
    assign access     = psel & penable & pready;
    assign wordAddr   = paddr[11:2];
    assign hitDivider = (wordAddr == clock_sleep_pkg::DIVIDER_ADDR[9:0] >> 2) ? 1'b1 : 1'b0;
    assign hitTrim    = (wordAddr == clock_sleep_pkg::TRIM_ADDR[9:0] >> 2) ? 1'b1 : 1'b0;
    assign hitSleep   = (wordAddr == clock_sleep_pkg::SLEEP_CTRL_ADDR[9:0] >> 2) ? 1'b1 : 1'b0;
    assign hitStatus  = (wordAddr == clock_sleep_pkg::STATUS_ADDR[9:0] >> 2) ? 1'b1 : 1'b0;
    assign mapped     = hitDivider | hitTrim | hitSleep | hitStatus;
    assign wrData     = pwdata[7:0];
    assign wrByte0    = clk_en & access & pwrite & pstrb[0];

    // Read data is captured in setup, so every access completes in one cycle while clk_en is high
    logic readLoaded_q;
    assign pready = clk_en & readLoaded_q;

    // State
    logic [7:0] trim_q;
    logic [3:0] divSel_q;
    logic [3:0] divPending_q;
    logic       divChange_q;
    logic       unlock_q;
    logic [2:0] unlockCount_q;
    logic [7:0] divCount_q;
    logic [7:0] sleepCtrl_q;
    state_t     state_q;
    mode_t      activeMode_q;
    logic [7:0] wakeCount_q;

    logic tickNow;
    assign tickNow = (divCount_q == divTerminal(divSel_q)) ? 1'b1 : 1'b0;

    // Write qualifiers for the divider register
    logic unlockWrite;
    logic selectWrite;
    assign unlockWrite = wrByte0 & hitDivider & (wrData == clock_sleep_pkg::UNLOCK_PATTERN);
    assign selectWrite = wrByte0 & hitDivider & unlock_q & ~wrData[clock_sleep_pkg::UNLOCK_BIT];

    // APB answer
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            readLoaded_q <= 1'b0;
            prdata       <= 32'h0000_0000;
            pslverr      <= 1'b0;
        end else if (clk_en) begin
            if (setup) begin
                readLoaded_q <= 1'b1;
                pslverr      <= ~mapped;
                prdata       <= 32'h0000_0000;
                if (hitDivider) begin
                    prdata[7:0] <= {unlock_q, 3'b000, divSel_q};
                end else if (hitTrim) begin
                    prdata[7:0] <= trim_q;
                end else if (hitSleep) begin
                    prdata[7:0] <= sleepCtrl_q;
                end else if (hitStatus) begin
                    prdata[7:0] <= {divChange_q, activeMode_q, 2'b00, state_q};
                end
            end else if (access) begin
                readLoaded_q <= 1'b0;
            end
        end
    end

    // Oscillator trim
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            trim_q <= factoryTrim;
        end else if (clk_en && wrByte0 && hitTrim) begin
            trim_q <= wrData;
        end
    end
    assign oscillatorTrim = trim_q;
    assign rangeSelectBit = trim_q[7];
    assign fineTrimBits   = trim_q[6:0];

    // Unlock window, counted in system clock cycles
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            unlock_q      <= 1'b0;
            unlockCount_q <= 3'h0;
        end else if (clk_en) begin
            if (selectWrite) begin
                unlock_q <= 1'b0;
            end else if (unlockWrite && !unlock_q) begin
                unlock_q      <= 1'b1;
                unlockCount_q <= 3'h0;
            end else if (unlock_q && tickNow) begin
                // Rewrites while open fall here and change nothing
                if (unlockCount_q == 3'(clock_sleep_pkg::UNLOCK_CYCLES - 1)) begin
                    unlock_q <= 1'b0;
                end
                unlockCount_q <= unlockCount_q + 3'h1;
            end
        end
    end

    // Divide select: pending value waits for the end of the old period
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            divSel_q     <= div8FuseProgrammed ? clock_sleep_pkg::DIV_RESET_DIV8
                                               : clock_sleep_pkg::DIV_RESET_FAST;
            divPending_q <= 4'h0;
            divChange_q  <= 1'b0;
        end else if (clk_en) begin
            if (selectWrite) begin
                divPending_q <= wrData[3:0];
                divChange_q  <= 1'b1;
            end else if (divChange_q && tickNow) begin
                divSel_q    <= divPending_q;
                divChange_q <= 1'b0;
            end
        end
    end

    // Master clock divider, restarted when a new division takes over
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            divCount_q <= 8'h00;
        end else if (clk_en) begin
            if (tickNow) begin
                divCount_q <= 8'h00;
            end else begin
                divCount_q <= divCount_q + 8'h01;
            end
        end
    end
    assign sysClkTick = clk_en & tickNow;

    // Sleep control register
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            sleepCtrl_q <= clock_sleep_pkg::SLEEP_CTRL_RESET;
        end else if (clk_en && wrByte0 && hitSleep) begin
            sleepCtrl_q <= {4'h0, wrData[3:0]};
        end
    end

    logic  sleepAllow;
    mode_t reqMode;
    logic  modeValid;
    logic  asyncPeripheral;
    assign sleepAllow      = sleepCtrl_q[clock_sleep_pkg::SLEEP_ALLOW_BIT];
    assign reqMode         = mode_t'(sleepCtrl_q[clock_sleep_pkg::MODE_LSB +: 3]);
    assign asyncPeripheral = lcdAsync | timer2Async;

    // Reserved codes and standby without crystal leave the sleep instruction inert
    always_comb begin
        case (reqMode)
            clock_sleep_pkg::MODE_IDLE:     modeValid = 1'b1;
            clock_sleep_pkg::MODE_ADC_NR:   modeValid = 1'b1;
            clock_sleep_pkg::MODE_PWR_DOWN: modeValid = 1'b1;
            clock_sleep_pkg::MODE_PWR_SAVE: modeValid = 1'b1;
            clock_sleep_pkg::MODE_STANDBY:  modeValid = extCrystalSelected;
            default:                        modeValid = 1'b0;
        endcase
    end

    // Wake qualification per active mode
    logic extZeroWake;
    logic wakeEvent;
    assign extZeroWake = extIntZero
                       & (extIntZeroLevel | (activeMode_q == clock_sleep_pkg::MODE_IDLE));

    always_comb begin
        case (activeMode_q)
            clock_sleep_pkg::MODE_IDLE:
                wakeEvent = extIntZero | pinChangeWake | serialStartWake | lcdWake
                          | timer2Wake | memReadyWake | converterWake | otherIoWake;
            clock_sleep_pkg::MODE_ADC_NR:
                wakeEvent = extZeroWake | pinChangeWake | serialStartWake | memReadyWake
                          | converterWake | (asyncPeripheral & (lcdWake | timer2Wake));
            clock_sleep_pkg::MODE_PWR_SAVE:
                wakeEvent = extZeroWake | pinChangeWake | serialStartWake
                          | (asyncPeripheral & (lcdWake | timer2Wake));
            default:
                wakeEvent = extZeroWake | pinChangeWake | serialStartWake;
        endcase
    end

    // Start-up wait before the four halt cycles
    logic [7:0] startupLen;
    always_comb begin
        case (activeMode_q)
            clock_sleep_pkg::MODE_PWR_DOWN: startupLen = 8'(STARTUP_CYCLES);
            clock_sleep_pkg::MODE_PWR_SAVE: startupLen = 8'(STARTUP_CYCLES);
            clock_sleep_pkg::MODE_STANDBY:  startupLen = 8'(clock_sleep_pkg::STANDBY_WAKE_CYCLES);
            default:                        startupLen = 8'h00;
        endcase
    end

    // Sleep sequencer; it never touches processor state, so contents survive
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_q      <= clock_sleep_pkg::ST_RUN;
            activeMode_q <= clock_sleep_pkg::MODE_IDLE;
            wakeCount_q  <= 8'h00;
        end else if (clk_en) begin
            case (state_q)
                clock_sleep_pkg::ST_RUN: begin
                    if (sleepInstr && sleepAllow && modeValid) begin
                        state_q      <= clock_sleep_pkg::ST_SLEEP;
                        activeMode_q <= reqMode;
                    end
                end
                clock_sleep_pkg::ST_SLEEP: begin
                    if (wakeEvent) begin
                        wakeCount_q <= 8'h00;
                        state_q     <= (startupLen == 8'h00) ? clock_sleep_pkg::ST_WAKE_HALT
                                                             : clock_sleep_pkg::ST_STARTUP;
                    end
                end
                clock_sleep_pkg::ST_STARTUP: begin
                    if (wakeCount_q == startupLen - 8'h01) begin
                        wakeCount_q <= 8'h00;
                        state_q     <= clock_sleep_pkg::ST_WAKE_HALT;
                    end else begin
                        wakeCount_q <= wakeCount_q + 8'h01;
                    end
                end
                clock_sleep_pkg::ST_WAKE_HALT: begin
                    if (wakeCount_q == 8'(clock_sleep_pkg::WAKE_HALT_CYCLES - 1)) begin
                        wakeCount_q <= 8'h00;
                        state_q     <= clock_sleep_pkg::ST_RUN;
                    end else begin
                        wakeCount_q <= wakeCount_q + 8'h01;
                    end
                end
                default: begin
                    state_q <= clock_sleep_pkg::ST_RUN;
                end
            endcase
        end
    end

    // Clock domain gating, registered
    logic cpuEn_d;
    logic ioEn_d;
    logic convEn_d;
    logic asyEn_d;
    logic mainEn_d;
    logic tOscEn_d;
    logic asleep;
    assign asleep = (state_q != clock_sleep_pkg::ST_RUN) ? 1'b1 : 1'b0;

    always_comb begin
        cpuEn_d  = ~asleep;
        ioEn_d   = 1'b1;
        convEn_d = 1'b1;
        asyEn_d  = 1'b1;
        mainEn_d = 1'b1;
        tOscEn_d = asyncPeripheral;
        if (state_q == clock_sleep_pkg::ST_SLEEP || state_q == clock_sleep_pkg::ST_STARTUP) begin
            case (activeMode_q)
                clock_sleep_pkg::MODE_IDLE: begin
                    tOscEn_d = asyncPeripheral;
                end
                clock_sleep_pkg::MODE_ADC_NR: begin
                    ioEn_d = 1'b0;
                end
                clock_sleep_pkg::MODE_PWR_SAVE: begin
                    ioEn_d   = 1'b0;
                    convEn_d = 1'b0;
                    mainEn_d = 1'b0;
                end
                clock_sleep_pkg::MODE_STANDBY: begin
                    ioEn_d   = 1'b0;
                    convEn_d = 1'b0;
                    asyEn_d  = 1'b0;
                    tOscEn_d = 1'b0;
                end
                default: begin
                    ioEn_d   = 1'b0;
                    convEn_d = 1'b0;
                    asyEn_d  = 1'b0;
                    mainEn_d = 1'b0;
                    tOscEn_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cpuClockEn       <= 1'b1;
            flashClockEn     <= 1'b1;
            ioClockEn        <= 1'b1;
            converterClockEn <= 1'b1;
            asyncClockEn     <= 1'b1;
            mainOscEn        <= 1'b1;
            timerOscEn       <= 1'b0;
        end else if (clk_en) begin
            cpuClockEn       <= cpuEn_d;
            flashClockEn     <= cpuEn_d;
            ioClockEn        <= ioEn_d;
            converterClockEn <= convEn_d;
            asyncClockEn     <= asyEn_d;
            mainOscEn        <= mainEn_d;
            timerOscEn       <= tOscEn_d;
        end
    end

    // Conversion start and resume pulses, and the sleeping flag
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            converterStart <= 1'b0;
            resumeRun      <= 1'b0;
            sleeping       <= 1'b0;
        end else if (clk_en) begin
            converterStart <= (state_q == clock_sleep_pkg::ST_RUN) & sleepInstr & sleepAllow
                            & converterEnabled
                            & ((reqMode == clock_sleep_pkg::MODE_IDLE)
                             | (reqMode == clock_sleep_pkg::MODE_ADC_NR));
            resumeRun      <= (state_q == clock_sleep_pkg::ST_WAKE_HALT)
                            & (wakeCount_q == 8'(clock_sleep_pkg::WAKE_HALT_CYCLES - 1));
            sleeping       <= (state_q == clock_sleep_pkg::ST_SLEEP);
        end
    end
endmodule : clock_divider_sleep_control

// ===== shared/clock_sleep_pkg.sv
// Register map, field layout, codes and counts of the clock and sleep controller
package clock_sleep_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] DIVIDER_IDX    = 8'h61;
    localparam logic [7:0] TRIM_IDX       = 8'h62;
    localparam logic [7:0] SLEEP_CTRL_IDX = 8'h63;
    localparam logic [7:0] STATUS_IDX     = 8'h64;
    localparam logic [9:0] DIVIDER_ADDR    = {DIVIDER_IDX, 2'b00};
    localparam logic [9:0] TRIM_ADDR       = {TRIM_IDX, 2'b00};
    localparam logic [9:0] SLEEP_CTRL_ADDR = {SLEEP_CTRL_IDX, 2'b00};
    localparam logic [9:0] STATUS_ADDR     = {STATUS_IDX, 2'b00};

    // Divider register fields
    localparam int         UNLOCK_BIT     = 7;
    localparam logic [7:0] UNLOCK_PATTERN = 8'h80;
    localparam logic [3:0] DIV_RESET_FAST = 4'h0;
    localparam logic [3:0] DIV_RESET_DIV8 = 4'h3;
    localparam logic [3:0] DIV_MAX_CODE   = 4'h8;
    localparam int         UNLOCK_CYCLES  = 4;

    // Sleep control fields
    localparam int         SLEEP_ALLOW_BIT = 0;
    localparam int         MODE_LSB        = 1;
    localparam logic [7:0] SLEEP_CTRL_RESET = 8'h00;

    // Wake timing in master clock cycles
    localparam int WAKE_HALT_CYCLES = 4;
    localparam int STANDBY_WAKE_CYCLES = 6;
    localparam int STARTUP_CYCLES_DEFAULT = 6;

    typedef enum logic [2:0] {
        MODE_IDLE      = 3'b000,
        MODE_ADC_NR    = 3'b001,
        MODE_PWR_DOWN  = 3'b010,
        MODE_PWR_SAVE  = 3'b011,
        MODE_RSVD_4    = 3'b100,
        MODE_RSVD_5    = 3'b101,
        MODE_STANDBY   = 3'b110,
        MODE_RSVD_7    = 3'b111
    } sleep_mode_t;

    typedef enum logic [1:0] {
        ST_RUN       = 2'b00,
        ST_SLEEP     = 2'b01,
        ST_STARTUP   = 2'b10,
        ST_WAKE_HALT = 2'b11
    } sleep_state_t;
endpackage : clock_sleep_pkg

// ===== sim/clock_divider_sleep_control_monitor.sv
// Checker of trim, divider, bus and sleep sequencing at the controller ports
`timescale 1ns/100ps
module clock_divider_sleep_control_monitor (
    input wire logic        ref_clk,
    input wire logic        reset_n,
    input wire logic        clk_en,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic [7:0]  factoryTrim,
    input wire logic [7:0]  oscillatorTrim,
    input wire logic        rangeSelectBit,
    input wire logic [6:0]  fineTrimBits,
    input wire logic        sysClkTick,
    input wire logic        sleeping,
    input wire logic        cpuClockEn,
    input wire logic        flashClockEn,
    input wire logic        converterStart,
    input wire logic        resumeRun
);
    logic [8:0] gapCnt_q;
    logic       mapped;
    assign mapped = paddr[11:2] >= 10'(clock_sleep_pkg::DIVIDER_IDX)
                 && paddr[11:2] <= 10'(clock_sleep_pkg::STATUS_IDX);
    // Cycles since the last divided tick
    always_ff @(posedge ref_clk) begin
        if (!reset_n || sysClkTick || sleeping || !clk_en)
            gapCnt_q <= 9'h000;
        else
            gapCnt_q <= gapCnt_q + 9'h001;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    property p_trim_load; $rose(reset_n) |-> oscillatorTrim == factoryTrim; endproperty
    property p_trim_split;
        rangeSelectBit == oscillatorTrim[7] && fineTrimBits == oscillatorTrim[6:0];
    endproperty
    property p_zero_wait; psel && !penable && clk_en ##1 psel && penable |-> pready; endproperty
    property p_unmapped; psel && !penable && clk_en && !mapped |=> pslverr && prdata == 32'h0;
    endproperty
    property p_div_ro; pready && paddr == 12'h184 |-> prdata[31:8] == 24'h0 && prdata[6:4] == 3'h0;
    endproperty
    property p_sleep_gate; sleeping [*3] |-> !cpuClockEn && !flashClockEn; endproperty
    property p_wake_halt; $fell(sleeping) |-> !resumeRun [*3]; endproperty
    property p_resume; resumeRun |-> !cpuClockEn ##1 cpuClockEn; endproperty
    property p_conv_start; converterStart |-> ##[0:1] sleeping; endproperty
    property p_tick_gap; gapCnt_q <= 9'h0FF; endproperty
    a_trim_load: assert property (p_trim_load) else $error("trim not loaded at reset");
    a_trim_split: assert property (p_trim_split) else $error("trim fields wrong");
    a_zero_wait: assert property (p_zero_wait) else $error("access phase not ready");
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    a_div_ro: assert property (p_div_ro) else $error("divider spare bits not zero");
    a_sleep_gate: assert property (p_sleep_gate) else $error("cpu clock on in sleep");
    a_wake_halt: assert property (p_wake_halt) else $error("resume too early");
    a_resume: assert property (p_resume) else $error("cpu clock not back");
    a_conv_start: assert property (p_conv_start) else $error("start outside sleep");
    a_tick_gap: assert property (p_tick_gap) else $error("tick gap above 256");
    c_sleep: cover property ($rose(sleeping));
    c_resume: cover property (resumeRun);
    c_long_gap: cover property (sysClkTick && gapCnt_q == 9'h0FF);
    c_err: cover property (pslverr);
endmodule : clock_divider_sleep_control_monitor

bind clock_divider_sleep_control clock_divider_sleep_control_monitor u_mon (
    .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .factoryTrim(factoryTrim), .oscillatorTrim(oscillatorTrim), .rangeSelectBit(rangeSelectBit),
    .fineTrimBits(fineTrimBits), .sysClkTick(sysClkTick), .sleeping(sleeping),
    .cpuClockEn(cpuClockEn), .flashClockEn(flashClockEn), .converterStart(converterStart),
    .resumeRun(resumeRun));

// ===== sim/tb_top.sv
// Self-checking bench of the clock divider and sleep controller
`timescale 1ns/100ps
module tb_top;
    typedef struct {logic [11:0] a; logic [7:0] w; logic [7:0] r; logic e;} row_t;
    logic ref_clk, reset_n, psel, penable, pwrite, fuse, xtal, convEn, sleepInstr, lvl, asy;
    logic convSeen = 1'b0;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] trimIn, wk, oscillatorTrim;
    logic pready, pslverr, err, sysClkTick, sleeping, resumeRun, converterStart;
    logic cpuEn, flashEn, ioEn, convClkEn, asyncEn, oscEn, tOscEn;
    int errors, samples_checked, n;
    row_t rows[6] = '{'{12'h188, 8'h7F, 8'h7F, 1'b0}, '{12'h188, 8'h80, 8'h80, 1'b0},
        '{12'h18C, 8'hFF, 8'h0F, 1'b0}, '{12'h184, 8'h70, 8'h00, 1'b0},
        '{12'h184, 8'h81, 8'h00, 1'b0}, '{12'h1A0, 8'h55, 8'h00, 1'b1}};

    clock_divider_sleep_control #(.STARTUP_CYCLES(2)) dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .factoryTrim(trimIn), .div8FuseProgrammed(fuse),
        .extCrystalSelected(xtal), .lcdAsync(asy), .timer2Async(1'b0),
        .converterEnabled(convEn), .sleepInstr(sleepInstr), .extIntZero(wk[0]),
        .extIntZeroLevel(lvl), .pinChangeWake(wk[1]), .serialStartWake(wk[2]),
        .lcdWake(wk[3]), .timer2Wake(wk[4]), .memReadyWake(wk[5]), .converterWake(wk[6]),
        .otherIoWake(wk[7]), .oscillatorTrim(oscillatorTrim), .rangeSelectBit(),
        .fineTrimBits(), .sysClkTick(sysClkTick), .cpuClockEn(cpuEn), .flashClockEn(flashEn),
        .ioClockEn(ioEn), .converterClockEn(convClkEn), .asyncClockEn(asyncEn),
        .mainOscEn(oscEn), .timerOscEn(tOscEn), .converterStart(converterStart),
        .sleeping(sleeping), .resumeRun(resumeRun));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (converterStart === 1'b1) convSeen <= 1'b1;

    task automatic report_and_stop;
        if (errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int k;
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, 24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            errors++;
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb

    task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        chk("read", {24'h0, exp}, rd);
    endtask : rdchk

    task automatic tg(input int g);
        int k;
        k = 0;
        @(negedge ref_clk);
        while (sysClkTick !== 1'b1 && k < 600) begin
            @(negedge ref_clk);
            k++;
        end
        k = 0;
        do begin
            @(negedge ref_clk);
            k++;
        end while (sysClkTick !== 1'b1 && k < 600);
        chk("tick gap", g, k);
    endtask : tg

    task automatic wr;
        n = 0;
        while (resumeRun !== 1'b1 && n < 60) begin
            @(negedge ref_clk);
            n++;
        end
        if (n == 60) begin
            errors++;
            report_and_stop();
        end
    endtask : wr

    task automatic sl(input logic [2:0] m, input logic [5:0] en, input logic [7:0] w,
                      input logic ex, input int lat);
        apb(1'b1, 12'h18C, {4'h0, m, 1'b1});
        @(posedge ref_clk) sleepInstr <= 1'b1;
        @(posedge ref_clk) sleepInstr <= 1'b0;
        repeat (4) @(negedge ref_clk);
        chk("sleeping", 1, sleeping);
        chk("enables", en, {cpuEn, flashEn, ioEn, convClkEn, asyncEn, oscEn});
        chk("timer osc", asy & (m[2:1] == 2'b00 || m == 3'b011), tOscEn);
        @(posedge ref_clk) wk <= w;
        if (ex) begin
            wr();
            chk("wake latency", 1, 32'(n >= lat));
        end else begin
            repeat (30) @(negedge ref_clk);
            chk("still asleep", 1, sleeping);
            @(posedge ref_clk) wk <= 8'h02;
            wr();
        end
        @(posedge ref_clk) wk <= 8'h00;
        repeat (3) @(posedge ref_clk);
    endtask : sl

    initial begin
        {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {fuse, xtal, sleepInstr, lvl, asy, wk} = '0;
        convEn = 1'b1;
        trimIn = 8'h5A;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(negedge ref_clk);
        chk("trim", 8'h5A, oscillatorTrim);
        rdchk(12'h184, 8'h00);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].w);
            rdchk(rows[i].a, rows[i].r);
            chk("slverr", rows[i].e, err);
        end
        tg(1);
        @(posedge ref_clk);
        {fuse, trimIn} <= {1'b1, 8'hA5};
        reset_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        rdchk(12'h184, 8'h03);
        chk("trim", 8'hA5, oscillatorTrim);
        tg(8);
        apb(1'b1, 12'h184, 8'h80);
        rdchk(12'h184, 8'h83);
        apb(1'b1, 12'h184, 8'h80);
        rdchk(12'h184, 8'h83);
        apb(1'b1, 12'h184, 8'h02);
        tg(4);
        rdchk(12'h184, 8'h02);
        apb(1'b1, 12'h184, 8'h80);
        repeat (24) @(negedge ref_clk);
        rdchk(12'h184, 8'h02);
        apb(1'b1, 12'h184, 8'h01);
        rdchk(12'h184, 8'h02);
        apb(1'b1, 12'h184, 8'h80);
        apb(1'b1, 12'h184, 8'h08);
        tg(256);
        for (int i = 0; i < 8; i++) sl(3'b000, 6'b001111, 8'h01 << i, 1'b1, 4);
        chk("conversion", 1, convSeen);
        lvl <= 1'b1;
        for (int i = 0; i < 8; i++) sl(3'b010, 6'b000000, 8'h01 << i, i < 3, 6);
        lvl <= 1'b0;
        sl(3'b010, 6'b000000, 8'h01, 1'b0, 6);
        sl(3'b001, 6'b000111, 8'h80, 1'b0, 4);
        sl(3'b011, 6'b000010, 8'h08, 1'b0, 6);
        asy <= 1'b1;
        sl(3'b011, 6'b000010, 8'h08, 1'b1, 6);
        asy <= 1'b0;
        apb(1'b1, 12'h18C, 8'h0D);
        @(posedge ref_clk) sleepInstr <= 1'b1;
        @(posedge ref_clk) sleepInstr <= 1'b0;
        repeat (4) @(negedge ref_clk);
        chk("standby refused", 0, sleeping);
        @(posedge ref_clk) xtal <= 1'b1;
        sl(3'b110, 6'b000001, 8'h02, 1'b1, 10);
        apb(1'b1, 12'h18C, 8'h05);
        @(posedge ref_clk) sleepInstr <= 1'b1;
        @(posedge ref_clk) sleepInstr <= 1'b0;
        repeat (4) @(negedge ref_clk);
        chk("sleeping", 1, sleeping);
        @(posedge ref_clk) reset_n <= 1'b0;
        @(posedge ref_clk) reset_n <= 1'b1;
        @(negedge ref_clk);
        chk("reset wake", 2'b01, {sleeping, cpuEn});
        report_and_stop();
    end
endmodule : tb_top
